// File: logic/frame_buffer.sv
// Small FIFO that holds latched frames while the store engine is busy.
`timescale 1ns/1ps
module frame_buffer #(
  parameter int DEPTH = 2
) (
  input logic clk,
  input logic resetn,
  frame_if.snk wr,
  frame_if.src rd
);
  import led_eeprom_pkg::*;
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    frame_type [DEPTH-1:0] mem;
    logic [PTR_W-1:0] wp;
    logic [PTR_W-1:0] rp;
    logic [PTR_W:0] cnt;
  } buf_state_type;

  buf_state_type q;
  buf_state_type d;
  logic push;
  logic pop;

  function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p);
    return (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction

  assign wr.ready = (q.cnt != (PTR_W + 1)'(DEPTH));
  assign rd.valid = (q.cnt != '0);
  assign rd.data = q.mem[q.rp];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = wr.data;
      d.wp = next_ptr(q.wp);
    end
    if (pop) begin
      d.rp = next_ptr(q.rp);
    end
    d.cnt = q.cnt + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// File: logic/frame_if.sv
// Valid/ready carrier for latched frames between the capture logic and the buffer.
`timescale 1ns/1ps
interface frame_if;
  import led_eeprom_pkg::*;
  logic valid;
  logic ready;
  frame_type data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface

// File: logic/led_eeprom_access.sv
// Frame latch timing, nonvolatile level store and readout load for the LED driver link.
//
// Notes on behaviour
// - Latch low 36 bits to addressed latch after delay.
// - Four-bit code selects doubling latch delay.
// - Address 1101b is the second store latch.
// - Channel levels in bits 6-0, 13-7, 20-14.
// - Stored levels start at factory value 7Fh.
// - Payload bits 27-21 of store latch discarded.
// - Store frames accepted only with key 5Ah.
// - Levels and duty setting both storable.
// - Address 1011b loads stored image into register.
// - Readout load keeps lower three address bits.
// - Readout shifts out on data output pair.
// - Readout levels in bits 6-0, 13-7, 20-14.
// - Readout duty, target, mode, delay code fields.
// - Mode code 00, 01 distinct; 10, 11 mode 2.
`timescale 1ns/1ps
module led_eeprom_access #(
  parameter int unsigned prog_cycles = led_eeprom_pkg::PROG_CYCLES,
  parameter led_eeprom_pkg::delay_table_type delay_cycles = led_eeprom_pkg::delay_cycles_table()
) (
  input logic clk,
  input logic resetn,
  input logic clk_in_pos,
  input logic clk_in_neg,
  input logic data_in_pos,
  input logic data_in_neg,
  input logic program_voltage_pin,
  output logic data_out_pos,
  output logic data_out_neg,
  output logic [led_eeprom_pkg::LEVEL_W-1:0] store_level_ch0,
  output logic [led_eeprom_pkg::LEVEL_W-1:0] store_level_ch1,
  output logic [led_eeprom_pkg::LEVEL_W-1:0] store_level_ch2,
  output logic [led_eeprom_pkg::DUTY_W-1:0] stored_max_duty,
  output logic [led_eeprom_pkg::TARGET_W-1:0] stored_anode_target,
  output logic [1:0] link_timing_mode,
  output logic [led_eeprom_pkg::DELAY_W-1:0] stored_latch_delay_code,
  output logic program_busy,
  output logic frame_ready,
  output logic latch_strobe,
  output logic [led_eeprom_pkg::ADDR_W-1:0] latch_addr,
  output logic [led_eeprom_pkg::PAY_W-1:0] latch_payload
);
  import led_eeprom_pkg::*;

  typedef struct packed {
    logic [FRAME_W-1:0] shift;
    logic edge_tgl;
    logic ack;
  } link_state_type;

  typedef struct packed {
    logic edge_s1;
    logic edge_s2;
    logic edge_s3;
    logic ack_s1;
    logic ack_s2;
    logic prog_s1;
    logic prog_s2;
    logic [FRAME_W-1:0] word_s1;
    logic [FRAME_W-1:0] word_s2;
    logic [TIMER_W-1:0] timer;
    logic timer_run;
    logic fire;
    frame_type fword;
    eng_state_type state;
    logic [TIMER_W-1:0] prog_cnt;
    logic [PAY_W-1:0] pend;
    logic [PAY_W-1:0] nv;
    logic [PAY_W-1:0] image;
    logic load_req;
    logic strobe;
    frame_type lframe;
    logic programmed;
  } core_state_type;

  link_state_type lq;
  link_state_type ld;
  core_state_type cq;
  core_state_type cd;
  logic [TIMER_W-1:0] dly;
  logic [TIMER_W-1:0] prog_last;
  logic eng_ready;
  logic key_ok;
  logic take;
  frame_type head;

  frame_if fin();
  frame_if fout();

  frame_buffer #(
    .DEPTH(2)
  ) u_buffer (
    .clk(clk),
    .resetn(resetn),
    .wr(fin),
    .rd(fout)
  );

  // The differential complements only matter to the analog receivers.
  assign data_out_pos = lq.shift[FRAME_W-1];
  assign data_out_neg = ~lq.shift[FRAME_W-1];

  // Link side: shift on every rising edge of the link clock.
  // The readout image and its request toggle are held steady by the core for
  // the whole gap the host must leave after a latch, so the first edge of the
  // next frame may take them directly; a synchroniser here would need edges
  // that a stopped link clock never gives.
  always_comb begin
    ld = lq;
    ld.edge_tgl = ~lq.edge_tgl;
    if (cq.load_req != lq.ack) begin
      ld.shift = {ADDR_READOUT[ADDR_W-2:0], cq.image, data_in_pos};
      ld.ack = cq.load_req;
    end else begin
      ld.shift = {lq.shift[FRAME_W-2:0], data_in_pos};
    end
  end

  always_ff @(posedge clk_in_pos or negedge resetn) begin
    if (!resetn) begin
      lq <= '0;
    end else begin
      lq <= ld;
    end
  end

  // Core side.
  assign dly = TIMER_W'(delay_cycles[cq.nv[DELAY_LSB +: DELAY_W]]);
  assign prog_last = TIMER_W'(prog_cycles - 1);
  assign head = fout.data;
  assign key_ok = (head.payload[KEY_LSB +: KEY_W] == WRITE_KEY);
  assign eng_ready = (cq.state == ENG_IDLE) && (cq.ack_s2 == cq.load_req);
  assign take = fout.valid && eng_ready;
  assign fout.ready = eng_ready;
  assign fin.valid = cq.fire;
  assign fin.data = cq.fword;
  assign frame_ready = fin.ready;

  always_comb begin
    cd = cq;
    cd.edge_s1 = lq.edge_tgl;
    cd.edge_s2 = cq.edge_s1;
    cd.edge_s3 = cq.edge_s2;
    cd.ack_s1 = lq.ack;
    cd.ack_s2 = cq.ack_s1;
    cd.prog_s1 = program_voltage_pin;
    cd.prog_s2 = cq.prog_s1;
    cd.word_s1 = lq.shift;
    cd.word_s2 = cq.word_s1;
    cd.fire = 1'b0;
    cd.strobe = 1'b0;
    if (cq.edge_s2 != cq.edge_s3) begin
      cd.timer = '0;
      cd.timer_run = 1'b1;
    end else if (cq.timer_run) begin
      if (cq.timer + TIMER_W'(1) >= dly) begin
        cd.timer_run = 1'b0;
        cd.fire = 1'b1;
        cd.fword = frame_type'(cq.word_s2);
      end else begin
        cd.timer = cq.timer + TIMER_W'(1);
      end
    end
    case (cq.state)
      ENG_IDLE: begin
        if (take) begin
          case (head.addr)
            ADDR_STORE2: begin
              if (key_ok && cq.prog_s2) begin
                // Bits 27-21 are never copied, so they cannot reach the store.
                cd.pend = cq.nv;
                cd.pend[LEVELS_W-1:0] = head.payload[LEVELS_W-1:0];
                cd.state = ENG_PROG;
                cd.prog_cnt = '0;
              end
            end
            ADDR_STORE1: begin
              if (key_ok && cq.prog_s2) begin
                cd.pend = cq.nv;
                cd.pend[DUTY_LSB +: DUTY_W] = head.payload[S1_DUTY_LSB +: DUTY_W];
                cd.pend[TARGET_LSB +: TARGET_W] = head.payload[S1_TARGET_LSB +: TARGET_W];
                cd.pend[MODE_LSB +: MODE_W] = head.payload[S1_MODE_LSB +: MODE_W];
                cd.pend[DELAY_LSB +: DELAY_W] = head.payload[S1_DELAY_LSB +: DELAY_W];
                cd.state = ENG_PROG;
                cd.prog_cnt = '0;
              end
            end
            ADDR_READOUT: begin
              cd.image = cq.nv;
              cd.image[RSV_BIT] = RSV_VALUE;
              cd.load_req = ~cq.load_req;
            end
            default: begin
              cd.strobe = 1'b1;
              cd.lframe = head;
            end
          endcase
        end
      end
      ENG_PROG: begin
        if (cq.prog_cnt == prog_last) begin
          cd.nv = cq.pend;
          cd.programmed = 1'b1;
          cd.state = ENG_IDLE;
        end else begin
          cd.prog_cnt = cq.prog_cnt + TIMER_W'(1);
        end
      end
      default: begin
        cd.state = ENG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cq <= '0;
      cq.nv <= NV_FACTORY;
      cq.image <= NV_FACTORY;
      cq.state <= ENG_IDLE;
    end else begin
      cq <= cd;
    end
  end

  assign store_level_ch0 = cq.nv[CH0_LSB +: LEVEL_W];
  assign store_level_ch1 = cq.nv[CH1_LSB +: LEVEL_W];
  assign store_level_ch2 = cq.nv[CH2_LSB +: LEVEL_W];
  assign stored_max_duty = cq.nv[DUTY_LSB +: DUTY_W];
  assign stored_anode_target = cq.nv[TARGET_LSB +: TARGET_W];
  assign link_timing_mode = decode_timing_mode(cq.nv[MODE_LSB +: MODE_W]);
  assign stored_latch_delay_code = cq.nv[DELAY_LSB +: DELAY_W];
  assign program_busy = (cq.state == ENG_PROG);
  assign latch_strobe = cq.strobe;
  assign latch_addr = cq.lframe.addr;
  assign latch_payload = cq.lframe.payload;

  // Checks.
  a_delay_restart: assert property (@(posedge clk) disable iff (!resetn)
    (cq.edge_s2 != cq.edge_s3) |=> (cq.timer == '0) && cq.timer_run && !cq.fire)
    else $error("Delay timer did not restart on a shift edge.");

  a_delay_expiry: assert property (@(posedge clk) disable iff (!resetn)
    (cq.timer_run && (cq.edge_s2 == cq.edge_s3) && (cq.timer + TIMER_W'(1) >= dly))
    |=> cq.fire && !cq.timer_run)
    else $error("Latch did not fire when the delay ran out.");

  a_latch_word: assert property (@(posedge clk) disable iff (!resetn)
    cq.fire |-> (cq.fword == frame_type'($past(cq.word_s2))) && !$past(cq.fire))
    else $error("Latched frame differs from the settled shift word.");

  a_latch_route: assert property (@(posedge clk) disable iff (!resetn)
    (take && (head.addr != ADDR_STORE1) && (head.addr != ADDR_STORE2)
     && (head.addr != ADDR_READOUT)) |=> latch_strobe && (latch_addr == $past(head.addr)))
    else $error("Volatile frame not passed on to its latch.");

  a_key_required: assert property (@(posedge clk) disable iff (!resetn)
    (take && !key_ok && ((head.addr == ADDR_STORE1) || (head.addr == ADDR_STORE2)))
    |=> (cq.state == ENG_IDLE) && !latch_strobe)
    else $error("Store frame without write key was accepted.");

  a_level_store: assert property (@(posedge clk) disable iff (!resetn)
    (take && (head.addr == ADDR_STORE2) && key_ok && cq.prog_s2)
    |=> program_busy && (cq.pend[LEVELS_W-1:0] == $past(head.payload[LEVELS_W-1:0]))
        && (cq.pend[PAY_W-1:LEVELS_W] == cq.nv[PAY_W-1:LEVELS_W]))
    else $error("Level store frame latched wrong or touched spare bits.");

  a_store_commit: assert property (@(posedge clk) disable iff (!resetn)
    (program_busy && (cq.prog_cnt == prog_last)) |=> !program_busy && (cq.nv == $past(cq.pend)))
    else $error("Pending store values were not committed.");

  a_factory_level: assert property (@(posedge clk) disable iff (!resetn)
    !cq.programmed |-> (store_level_ch0 == LEVEL_FACTORY) && (store_level_ch1 == LEVEL_FACTORY)
        && (store_level_ch2 == LEVEL_FACTORY))
    else $error("Levels left factory value without programming.");

  a_readout_image: assert property (@(posedge clk) disable iff (!resetn)
    (take && (head.addr == ADDR_READOUT))
    |=> (cq.image[PAY_W-2:0] == $past(cq.nv[PAY_W-2:0])) && (cq.load_req != $past(cq.load_req)))
    else $error("Readout image or load request wrong.");

  a_mode_decode: assert property (@(posedge clk) disable iff (!resetn)
    cq.nv[MODE_LSB + 1] |-> (link_timing_mode == 2'h2))
    else $error("Timing mode code 1x did not select mode 2.");

  a_readout_load: assert property (@(posedge clk_in_pos) disable iff (!resetn)
    (cq.load_req != lq.ack)
    |=> (lq.shift[FRAME_W-1 -: ADDR_W - 1] == ADDR_READOUT[ADDR_W-2:0]) && (lq.ack == cq.load_req))
    else $error("Readout load lost the address bits.");

  a_shift_out: assert property (@(posedge clk_in_pos) disable iff (!resetn)
    (cq.load_req == lq.ack) |=> (lq.shift[FRAME_W-1:1] == $past(lq.shift[FRAME_W-2:0])))
    else $error("Shift register did not shift by one bit.");

  c_latch_fire: cover property (@(posedge clk) disable iff (!resetn) cq.fire);
  c_readout: cover property (@(posedge clk) disable iff (!resetn)
    take && (head.addr == ADDR_READOUT));
  c_commit: cover property (@(posedge clk) disable iff (!resetn) $fell(program_busy));
  c_buffer_full: cover property (@(posedge clk) disable iff (!resetn) !frame_ready);
endmodule

// File: logic/led_eeprom_pkg.sv
// Shared constants, types and helpers for the LED driver frame latch and store logic.
package led_eeprom_pkg;
  localparam int FRAME_W = 40;
  localparam int PAY_W = 36;
  localparam int ADDR_W = 4;
  localparam int LEVEL_W = 7;
  localparam int LEVELS_W = 21;
  localparam int KEY_LSB = 28;
  localparam int KEY_W = 8;
  localparam int TIMER_W = 20;
  localparam logic [ADDR_W-1:0] ADDR_READOUT = 4'hB;
  localparam logic [ADDR_W-1:0] ADDR_STORE1 = 4'hC;
  localparam logic [ADDR_W-1:0] ADDR_STORE2 = 4'hD;
  localparam logic [KEY_W-1:0] WRITE_KEY = 8'h5A;
  localparam int CH0_LSB = 0;
  localparam int CH1_LSB = 7;
  localparam int CH2_LSB = 14;
  localparam int DUTY_LSB = 21;
  localparam int DUTY_W = 3;
  localparam int TARGET_LSB = 24;
  localparam int TARGET_W = 5;
  localparam int MODE_LSB = 29;
  localparam int MODE_W = 2;
  localparam int DELAY_LSB = 31;
  localparam int DELAY_W = 4;
  localparam int RSV_BIT = 35;
  localparam int CFG_LSB = 21;
  localparam int CFG_W = 14;
  localparam int S1_DUTY_LSB = 0;
  localparam int S1_TARGET_LSB = 3;
  localparam int S1_MODE_LSB = 8;
  localparam int S1_DELAY_LSB = 10;
  localparam logic [LEVEL_W-1:0] LEVEL_FACTORY = 7'h7F;
  localparam logic [DUTY_W-1:0] DUTY_FACTORY = 3'h0;
  localparam logic [TARGET_W-1:0] TARGET_FACTORY = 5'h00;
  localparam logic [MODE_W-1:0] MODE_FACTORY = 2'h0;
  localparam logic [DELAY_W-1:0] DELAY_FACTORY = 4'h0;
  localparam logic RSV_VALUE = 1'b0;
  localparam logic [PAY_W-1:0] NV_FACTORY = {RSV_VALUE, DELAY_FACTORY, MODE_FACTORY,
    TARGET_FACTORY, DUTY_FACTORY, LEVEL_FACTORY, LEVEL_FACTORY, LEVEL_FACTORY};
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned PROG_TIME_MS = 40;
  localparam int unsigned PROG_CYCLES = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;

  typedef int unsigned delay_table_type [16];
  localparam delay_table_type DELAY_MIN_NS = '{300, 600, 1300, 2600, 5300, 10000, 21000,
    42000, 85000, 170000, 341000, 682000, 1365000, 2730000, 5461000, 10922000};

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_PROG = 2'b01
  } eng_state_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [PAY_W-1:0] payload;
  } frame_type;

  function automatic int unsigned ns_to_cycles(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c == 0) ? 1 : c;
  endfunction

  function automatic delay_table_type delay_cycles_table();
    delay_table_type t;
    for (int i = 0; i < 16; i++) begin
      t[i] = ns_to_cycles(DELAY_MIN_NS[i]);
    end
    return t;
  endfunction

  function automatic logic [1:0] decode_timing_mode(input logic [MODE_W-1:0] code);
    return code[1] ? 2'h2 : {1'b0, code[0]};
  endfunction
endpackage

// File: testbench/host_link.sv
// Host side of the serial link: shifts frames in and samples the positive data output.
`timescale 1ns/1ps
module host_link (
  output logic clk_in_pos,
  output logic clk_in_neg,
  output logic data_in_pos,
  output logic data_in_neg,
  input logic data_out_pos
);
  realtime last_edge;
  initial begin
    clk_in_pos = 1'b0;
    clk_in_neg = 1'b1;
    data_in_pos = 1'b0;
    data_in_neg = 1'b1;
    last_edge = 0;
  end
  // Shifts v[n-1:0] MSB first; the clock stands low between frames.
  task automatic shift(input logic [39:0] v, input int n, output logic [39:0] seen);
    seen = '0;
    #7;
    for (int i = n - 1; i >= 0; i--) begin
      data_in_pos = v[i];
      data_in_neg = ~v[i];
      #16;
      seen = {seen[38:0], data_out_pos};
      clk_in_pos = 1'b1;
      clk_in_neg = 1'b0;
      last_edge = $realtime;
      #16;
      clk_in_pos = 1'b0;
      clk_in_neg = 1'b1;
    end
    // Released data shows the inverse of the last bit, so no stale level passes.
    data_in_pos = ~data_in_pos;
    data_in_neg = ~data_in_neg;
  endtask
endmodule

// File: testbench/tb.sv
// Self-checking bench for the frame latch, level store and readout load.
`timescale 1ns/1ps
module tb;
  import led_eeprom_pkg::*;
  localparam delay_table_type DLY = '{4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17, 18, 19};
  localparam int unsigned PROG = 200;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic program_voltage_pin = 1'b0;
  logic clk_in_pos, clk_in_neg, data_in_pos, data_in_neg, data_out_pos, data_out_neg;
  logic [6:0] ch0, ch1, ch2;
  logic [2:0] duty_o;
  logic [4:0] tgt_o;
  logic [1:0] mode_o;
  logic [3:0] dly_o, latch_addr;
  logic program_busy, frame_ready, latch_strobe;
  logic [35:0] latch_payload;
  logic [31:0] lfsr = 32'hF83A1CAC;
  logic [39:0] exp_q[$];
  logic [39:0] s;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int strobes = 0;
  realtime t_strobe;
  int lv[3] = '{127, 127, 127};
  int duty = 0, tgt = 0, mcode = 0, dcode = 0;

  always #50 clk = ~clk;

  host_link host (.clk_in_pos(clk_in_pos), .clk_in_neg(clk_in_neg), .data_in_pos(data_in_pos),
    .data_in_neg(data_in_neg), .data_out_pos(data_out_pos));

  led_eeprom_access #(.prog_cycles(PROG), .delay_cycles(DLY)) dut (.clk(clk), .resetn(resetn),
    .clk_in_pos(clk_in_pos), .clk_in_neg(clk_in_neg), .data_in_pos(data_in_pos),
    .data_in_neg(data_in_neg), .program_voltage_pin(program_voltage_pin),
    .data_out_pos(data_out_pos), .data_out_neg(data_out_neg), .store_level_ch0(ch0),
    .store_level_ch1(ch1), .store_level_ch2(ch2), .stored_max_duty(duty_o),
    .stored_anode_target(tgt_o), .link_timing_mode(mode_o), .stored_latch_delay_code(dly_o),
    .program_busy(program_busy), .frame_ready(frame_ready), .latch_strobe(latch_strobe),
    .latch_addr(latch_addr), .latch_payload(latch_payload));

  function automatic logic [35:0] rnd();
    logic [63:0] r;
    for (int i = 0; i < 64; i++) begin
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      r[i] = lfsr[0];
    end
    return r[35:0];
  endfunction

  task automatic stop_test();
    if (err_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_range(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  function automatic logic [34:0] image();
    return {4'(dcode), 2'(mcode), 5'(tgt), 3'(duty), 7'(lv[2]), 7'(lv[1]), 7'(lv[0])};
  endfunction

  task automatic chk_state();
    logic [1:0] m;
    m = mcode[1] ? 2'h2 : {1'b0, mcode[0]};
    chk({5'h00, dly_o, mode_o, tgt_o, duty_o, ch2, ch1, ch0},
      {5'h00, 4'(dcode), m, 5'(tgt), 3'(duty), 7'(lv[2]), 7'(lv[1]), 7'(lv[0])});
  endtask

  // Every strobe is compared with the oldest expected frame.
  always @(negedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      stop_test();
    end
    if (resetn && latch_strobe === 1'b1) begin
      strobes++;
      t_strobe = $realtime;
      chk({latch_addr, latch_payload}, exp_q.size() ? exp_q.pop_front() : 'x);
    end
  end

  // A pause shorter than the delay inside a frame must not latch it early.
  task automatic timed_frame(input logic [3:0] a, input int pause);
    logic [39:0] f;
    int n0;
    f = {a, rnd()};
    n0 = strobes;
    exp_q.push_back(f);
    if (pause > 0) begin
      host.shift(f >> 20, 20, s);
      repeat (pause) @(negedge clk);
      host.shift(f, 20, s);
    end else begin
      host.shift(f, 40, s);
    end
    for (int k = 0; k < 80 && strobes == n0; k++) @(negedge clk);
    chk_range(int'((t_strobe - host.last_edge) / 100), DLY[dcode], DLY[dcode] + 8);
    repeat (5) @(negedge clk);
    chk(40'(strobes), 40'(n0 + 1));
  endtask

  task automatic store(input logic [3:0] a, input logic [7:0] key, input logic [27:0] p,
      input logic pin, input int hold);
    @(negedge clk);
    program_voltage_pin = pin;
    host.shift({a, key, p}, 40, s);
    repeat (hold) @(negedge clk);
    if (pin && key == WRITE_KEY && a == ADDR_STORE2) begin
      lv = '{int'(p[6:0]), int'(p[13:7]), int'(p[20:14])};
    end
    if (pin && key == WRITE_KEY && a == ADDR_STORE1) begin
      dcode = int'(p[13:10]);
      mcode = int'(p[9:8]);
      tgt = int'(p[7:3]);
      duty = int'(p[2:0]);
    end
    @(negedge clk);
    program_voltage_pin = 1'b0;
  endtask

  initial begin
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    chk_state();
    chk({35'h0, frame_ready, program_busy, latch_strobe, data_out_neg, data_out_pos},
      40'h0000000012);
    timed_frame(4'h3, 0);
    timed_frame(4'h5, DLY[0] - 2);
    for (int m = 0; m < 4; m++) begin
      store(ADDR_STORE1, WRITE_KEY, (28'(rnd()) & 28'hFFFFCFF) | 28'(m << 8), 1'b1,
        DLY[dcode] + PROG + 20);
      chk_state();
      timed_frame(4'h7, 0);
    end
    store(ADDR_STORE2, WRITE_KEY, 28'(rnd()), 1'b1, DLY[dcode] + PROG + 20);
    chk_state();
    store(ADDR_STORE2, ~WRITE_KEY, 28'(rnd()), 1'b1, DLY[dcode] + PROG + 20);
    chk_state();
    store(ADDR_STORE2, WRITE_KEY, 28'(rnd()), 1'b0, DLY[dcode] + PROG + 20);
    chk_state();
    host.shift({ADDR_READOUT, rnd()}, 40, s);
    repeat (DLY[dcode] + 12) @(negedge clk);
    // The readout shift leaves an all-zero frame behind, which latches to address zero.
    exp_q.push_back(40'h0000000000);
    host.shift(40'h0000000000, 40, s);
    chk(s & ~(40'h1 << 35), {ADDR_READOUT, 1'b0, image()});
    chk(40'(data_out_neg ^ data_out_pos), 40'h0000000001);
    repeat (DLY[dcode] + 12) @(negedge clk);
    // Two frames sent while the store engine is busy must wait in the buffer.
    store(ADDR_STORE2, WRITE_KEY, 28'(rnd()), 1'b1, DLY[dcode] + 12);
    for (int k = 0; k < 2; k++) begin
      exp_q.push_back({4'(k + 1), rnd()});
      host.shift(exp_q[k], 40, s);
      repeat (DLY[dcode] + 12) @(negedge clk);
    end
    chk(40'({frame_ready, program_busy}), 40'h0000000001);
    repeat (PROG + 40) @(negedge clk);
    chk_state();
    chk(40'(exp_q.size()), 40'h0000000000);
    stop_test();
  end
endmodule
